/* src/tsc_pkg.sv */
// Constants and state types of the serial configuration and timing block
package tsc_pkg;

  // Crystal periods (sys_clk) per basic digital cycle
  localparam int DCLK_DIV = 16;
  localparam int DCLK_W = $clog2(DCLK_DIV);
  localparam logic [DCLK_W-1:0] DCLK_LAST = DCLK_W'(DCLK_DIV - 1);

  // Extended cycle factors per baud range, limit select set and cleared
  localparam int XF_W = 5;
  localparam logic [XF_W-1:0] XF_LIM [4] = '{5'h10, 5'h08, 5'h04, 5'h02};
  localparam logic [XF_W-1:0] XF_STD [4] = '{5'h08, 5'h04, 5'h02, 5'h01};

  // Least spacing of output edges in transparent mode, extended cycles
  localparam int DATA_MIN_W = 4;
  localparam logic [DATA_MIN_W-1:0] DATA_MIN_XCYC = 4'hA;

  // Chip select inactive time, tenths of a basic cycle, and in sys_clk
  localparam int CS_DIS_TENTHS = 15;
  localparam int CS_GAP_CYC = (CS_DIS_TENTHS * DCLK_DIV + 9) / 10;
  localparam int GAP_W = 5;
  localparam logic [GAP_W-1:0] CS_GAP_LIM = GAP_W'(CS_GAP_CYC);

  // Serial word
  localparam int WORD_W = 8;
  localparam int BIT_W = $clog2(WORD_W);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_W - 1);

  // System clock domain state
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [DCLK_W-1:0] dclk_cnt;
    logic [XF_W-1:0] xcnt;
    logic xtick;
    logic [DATA_MIN_W-1:0] tm_gap;
    logic tm_out;
    logic [GAP_W-1:0] gap_cnt;
    logic gap_err;
    logic [WORD_W-1:0] tx_hold;
    logic [WORD_W-1:0] rx_data;
    logic rx_valid;
  } tsc_sys_t;

  // Serial clock rising edge state, cleared outside a frame
  typedef struct packed {
    logic [BIT_W-1:0] bit_cnt;
    logic [WORD_W-2:0] shift;
  } tsc_rise_t;

  // Serial clock rising edge state that survives the end of a frame
  typedef struct packed {
    logic [WORD_W-1:0] rx_word;
    logic tog;
  } tsc_word_t;

  // Serial clock falling edge state
  typedef struct packed {
    logic started;
    logic out_bit;
    logic [WORD_W-2:0] shift;
  } tsc_fall_t;

endpackage

/* src/tsc_top.sv */
// Serial configuration port and transparent receive data timing
`timescale 1ns/1ps

module tsc_top (
  input wire logic sys_clk, // Crystal clock
  input wire logic rst_n, // Asynchronous reset
  input wire logic spi_sck, // Serial clock from master
  input wire logic spi_cs, // Chip select, active high
  input wire logic serial_in_test_data_in, // Serial data from master
  output logic serial_out_test_data_out, // Serial or test data out
  output logic serial_out_oe, // Output enable of data out
  input wire logic extended_limit_select, // Extended cycle factors
  input wire logic [1:0] baud_range_select, // Baud range 0 to 3
  input wire logic transparent_mode, // Receive transparent mode
  input wire logic rx_demod_data, // Demodulated receive data
  input wire logic [tsc_pkg::WORD_W-1:0] tx_data, // Next word to send
  output logic [tsc_pkg::WORD_W-1:0] rx_data, // Last word received
  output logic rx_valid, // Word received pulse
  output logic cs_gap_error // Select low time too short pulse
);
  import tsc_pkg::*;

  tsc_sys_t s_r;
  tsc_sys_t s_nxt;
  tsc_rise_t r_r;
  tsc_rise_t r_nxt;
  tsc_word_t w_r;
  tsc_word_t w_nxt;
  tsc_fall_t f_r;
  tsc_fall_t f_nxt;
  logic frame_rst_n;
  logic [XF_W-1:0] factor;
  logic dtick;
  logic rx_edge;
  logic cs_rise;
  logic spi_bit;
  logic [WORD_W-2:0] f_shift;

  // Serial bit count and shift logic is held in reset outside a frame; the received word is not
  assign frame_rst_n = rst_n & spi_cs;

  // System domain
  always_comb begin
    s_nxt = s_r;
    s_nxt.cs_s1 = spi_cs;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.cs_s3 = s_r.cs_s2;
    s_nxt.tog_s1 = w_r.tog;
    s_nxt.tog_s2 = s_r.tog_s1;
    s_nxt.tog_s3 = s_r.tog_s2;
    dtick = (s_r.dclk_cnt == DCLK_LAST);
    if (extended_limit_select) begin
      factor = XF_LIM[baud_range_select];
    end else begin
      factor = XF_STD[baud_range_select];
    end
    s_nxt.dclk_cnt = dtick ? '0 : s_r.dclk_cnt + 1'b1;
    s_nxt.xtick = 1'b0;
    if (dtick) begin
      // A factor lowered mid-count wraps at the next basic cycle end instead of overrunning
      if (s_r.xcnt >= factor - 1'b1) begin
        s_nxt.xcnt = '0;
        s_nxt.xtick = 1'b1;
      end else begin
        s_nxt.xcnt = s_r.xcnt + 1'b1;
      end
    end
    if (s_r.xtick && s_r.tm_gap != DATA_MIN_XCYC) begin
      s_nxt.tm_gap = s_r.tm_gap + 1'b1;
    end
    // Edge passes only after ten whole extended cycles; timing restarts
    if (transparent_mode && rx_demod_data != s_r.tm_out &&
        s_r.tm_gap == DATA_MIN_XCYC) begin
      s_nxt.tm_out = rx_demod_data;
      s_nxt.tm_gap = '0;
      s_nxt.dclk_cnt = '0;
      s_nxt.xcnt = '0;
      s_nxt.xtick = 1'b0;
    end
    rx_edge = s_r.tog_s2 ^ s_r.tog_s3;
    s_nxt.rx_valid = rx_edge;
    if (rx_edge) begin
      s_nxt.rx_data = w_r.rx_word;
    end
    // Next word is taken while idle and at each word boundary
    if (!s_r.cs_s2 || rx_edge) begin
      s_nxt.tx_hold = tx_data;
    end
    cs_rise = s_r.cs_s2 & ~s_r.cs_s3;
    s_nxt.gap_err = 1'b0;
    if (cs_rise) begin
      s_nxt.gap_err = (s_r.gap_cnt < CS_GAP_LIM);
      s_nxt.gap_cnt = '0;
    end else if (!s_r.cs_s2 && s_r.gap_cnt != CS_GAP_LIM) begin
      s_nxt.gap_cnt = s_r.gap_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.tm_gap <= DATA_MIN_XCYC;
      s_r.gap_cnt <= CS_GAP_LIM;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Serial clock rising edge: sample input
  always_comb begin
    r_nxt = r_r;
    w_nxt = w_r;
    r_nxt.shift = {r_r.shift[WORD_W-3:0], serial_in_test_data_in};
    r_nxt.bit_cnt = r_r.bit_cnt + 1'b1;
    if (r_r.bit_cnt == BIT_LAST) begin
      w_nxt.rx_word = {r_r.shift, serial_in_test_data_in};
      w_nxt.tog = ~w_r.tog;
    end
  end

  always_ff @(posedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Received word and toggle survive the end of a frame
  always_ff @(posedge spi_sck or negedge rst_n) begin
    if (!rst_n) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  // Serial clock falling edge: present next output bit
  // First falling edge of a frame shifts from the held word itself
  always_comb begin
    f_shift = f_r.started ? f_r.shift : s_r.tx_hold[WORD_W-2:0];
    f_nxt = f_r;
    f_nxt.started = 1'b1;
    if (r_r.bit_cnt == '0) begin
      f_nxt.out_bit = s_r.tx_hold[WORD_W-1];
      f_nxt.shift = s_r.tx_hold[WORD_W-2:0];
    end else begin
      f_nxt.out_bit = f_shift[WORD_W-2];
      f_nxt.shift = {f_shift[WORD_W-3:0], 1'b0};
    end
  end

  always_ff @(negedge spi_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  // First bit of a frame is shown before any falling edge
  assign spi_bit = f_r.started ? f_r.out_bit : s_r.tx_hold[WORD_W-1];
  assign serial_out_test_data_out = s_r.cs_s2 ? spi_bit : s_r.tm_out;
  assign serial_out_oe = s_r.cs_s2 | transparent_mode;
  assign rx_data = s_r.rx_data;
  assign rx_valid = s_r.rx_valid;
  assign cs_gap_error = s_r.gap_err;

endmodule

/* tb/transceiver_serial_config_timing_tb_top.sv */
// Bench for the serial configuration and timing block
`timescale 1ns/1ps
module transceiver_serial_config_timing_tb_top;
  import tsc_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, lim = 1'b0, tm = 1'b0, dm = 1'b0;
  logic sck, cs, mosi, oe, sdo, rxv, gerr;
  logic [1:0] br = 2'h0;
  logic [WORD_W-1:0] txd = 8'h00, rxd, got_d;
  int fails = 0, samples_checked = 0, cyc = 0, gap_hits = 0;
  tsc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(sck), .spi_cs(cs),
    .serial_in_test_data_in(mosi), .serial_out_test_data_out(sdo),
    .serial_out_oe(oe), .extended_limit_select(lim), .baud_range_select(br),
    .transparent_mode(tm), .rx_demod_data(dm), .tx_data(txd), .rx_data(rxd),
    .rx_valid(rxv), .cs_gap_error(gerr));
  tsc_master m_u (.sck(sck), .cs(cs), .mosi(mosi), .miso(oe ? sdo : 1'bz));
  initial forever #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rxv)
      got_d <= rxd;
    if (gerr)
      gap_hits <= gap_hits + 1;
    if (cyc == 30000) begin
      fails++;
      results();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_frame(input logic [7:0] w, input logic [7:0] t);
    logic [7:0] r;
    @(posedge sys_clk) txd <= t;
    repeat (4) @(posedge sys_clk);
    m_u.xfer(w, r);
    check(16'(r), 16'(t));
    check(16'(got_d), 16'(w));
    check(16'(oe), 16'h0000);
  endtask
  task automatic t_gap();
    int h;
    h = gap_hits;
    check(16'(h), 16'h0000);
    m_u.blip();
    check(16'(gap_hits - h), 16'h0001);
    check(16'(oe), 16'h0000);
  endtask
  task automatic wait_edge(output int n);
    n = 0;
    while (sdo !== dm && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask
  task automatic t_transp();
    int n;
    int g;
    @(posedge sys_clk) tm <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      g = ((i > 3) ? 2560 : 1280) >> (i % 4);
      @(posedge sys_clk) {lim, br} <= 3'(i);
      dm <= ~dm;
      @(posedge sys_clk);
      wait_edge(n);
      @(posedge sys_clk) dm <= ~dm;
      @(posedge sys_clk);
      wait_edge(n);
      check(16'(n >= g - 2 && n < g + 3), 16'h0001);
    end
  endtask
  task automatic t_sens();
    int n;
    @(posedge sys_clk) {lim, br} <= 3'h3;
    for (int i = 0; i < 4; i++) begin
      repeat (1000) @(posedge sys_clk);
      @(posedge sys_clk) dm <= ~dm;
      @(posedge sys_clk);
      wait_edge(n);
      check(16'(n), 16'h0001);
    end
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_frame(8'h3C, 8'hA5);
    t_frame(8'hC3, 8'h5A);
    t_gap();
    t_transp();
    t_sens();
    results();
  end
endmodule
bind tsc_top tsc_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .spi_sck(spi_sck), .spi_cs(spi_cs), .serial_out_oe(serial_out_oe),
  .serial_out_test_data_out(serial_out_test_data_out), .rx_data(rx_data),
  .extended_limit_select(extended_limit_select), .rx_valid(rx_valid),
  .baud_range_select(baud_range_select), .transparent_mode(transparent_mode));

/* tb/tsc_master.sv */
// Serial port master model
`timescale 1ns/1ps
module tsc_master (
  output logic sck, // Clock, idles low
  output logic cs, // Select
  output logic mosi, // Data to device
  input wire logic miso // Data from device
);
  initial begin
    sck = 1'b0;
    cs = 1'b0;
    mosi = 1'b1;
  end
  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    #7 cs = 1'b1;
    #1000;
    for (int i = 7; i >= 0; i--) begin
      mosi = w[i];
      #1000 sck = 1'b1;
      r[i] = miso;
      #1000 sck = 1'b0;
    end
    #1000 cs = 1'b0;
    mosi = ~mosi;
    #1000;
  endtask
  // Select pulses around a deliberately short low time, no clock edges
  task automatic blip();
    #1007 cs = 1'b1;
    #1000 cs = 1'b0;
    #400 cs = 1'b1;
    #1000 cs = 1'b0;
    #1000;
  endtask
endmodule

/* tb/tsc_props.sv */
// Timing checks on the serial port and transparent output
`timescale 1ns/1ps
module tsc_props (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic spi_sck, // Serial clock
  input wire logic spi_cs, // Select
  input wire logic serial_out_test_data_out, // Data out
  input wire logic serial_out_oe, // Enable
  input wire logic extended_limit_select, // Factor set
  input wire logic [1:0] baud_range_select, // Range
  input wire logic transparent_mode, // Mode
  input wire logic [tsc_pkg::WORD_W-1:0] rx_data, // Word
  input wire logic rx_valid // Word pulse
);
  logic [11:0] cnt_r;
  logic [11:0] gap;
  logic [3:0] hold_r;
  logic prev_r;
  logic edge_c;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  assign gap = (extended_limit_select ? 12'hA00 : 12'h500) >>
    baud_range_select;
  assign edge_c = serial_out_test_data_out != prev_r && !(|hold_r);
  // Edge spacing counter, parked at full while mode or setting moves
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 12'hFFF;
      hold_r <= 4'hF;
      prev_r <= 1'b0;
    end else begin
      prev_r <= serial_out_test_data_out;
      hold_r <= {hold_r[2:0], spi_cs | !transparent_mode |
        $changed({extended_limit_select, baud_range_select})};
      if (|hold_r)
        cnt_r <= 12'hFFF;
      else if (serial_out_test_data_out != prev_r)
        cnt_r <= 12'h001;
      else if (cnt_r != 12'hFFF)
        cnt_r <= cnt_r + 12'h001;
    end
  end
  chk_edge_gap: assert property (edge_c |-> cnt_r >= gap)
    else $error("edges too close");
  chk_out_enable: assert property ($rose(spi_cs) |-> ##2 serial_out_oe)
    else $error("no enable");
  chk_out_release: assert property
    ($fell(spi_cs) && !transparent_mode |-> ##2 !serial_out_oe)
    else $error("no release");
  chk_shift_fall: assert property
    ($changed(serial_out_test_data_out) && spi_cs && $past(spi_cs, 3)
      |-> !spi_sck) else $error("shift off falling edge");
  chk_sel_drive: assert property
    (spi_cs && $past(spi_cs, 2) |-> serial_out_oe) else $error("not driven");
  chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("long pulse");
  chk_rx_stable: assert property (!rx_valid |-> $stable(rx_data))
    else $error("word moved");
endmodule
